// ==== src/ads_defines.svh ====
// Address map, field positions and reset values of the sample status block.
// Assumes the register port presents one byte-wide address per access.
`ifndef ADS_DEFINES_SVH
`define ADS_DEFINES_SVH

// Status register and the axis high-byte output registers
`define ADS_STATUS_ADDR 8'h00
`define ADS_OUT_X_MSB_ADDR 8'h01
`define ADS_OUT_Y_MSB_ADDR 8'h03
`define ADS_OUT_Z_MSB_ADDR 8'h05

// Field positions inside the status byte
`define ADS_BIT_ZYXOW 7
`define ADS_BIT_ZOW 6
`define ADS_BIT_YOW 5
`define ADS_BIT_XOW 4
`define ADS_BIT_ZYXDR 3
`define ADS_BIT_ZDR 2
`define ADS_BIT_YDR 1
`define ADS_BIT_XDR 0

// Reset values
`define ADS_STATUS_RESET 8'h00
`define ADS_READ_IDLE 8'h00
`define ADS_SEEN_RESET 3'h0

`endif

// ==== src/ads_pkg.sv ====
// Types shared by the sample status block and its flag cells.
// Assumes ads_defines.svh carries all numeric constants.
package ads_pkg;

	// Register byte and register address
	typedef logic [7:0] ads_byte_t;
	typedef logic [7:0] ads_addr_t;

	// One bit per axis, index 0 is X, 1 is Y, 2 is Z
	typedef logic [2:0] ads_axis_t;

	// FIFO mode field; only the disabled mode shows the sample status view
	typedef enum logic [1:0] {
		ADS_FM_DISABLED = 2'h0,
		ADS_FM_CIRCULAR = 2'h1,
		ADS_FM_STOP = 2'h2,
		ADS_FM_TRIGGER = 2'h3
	} ads_fmode_t;

endpackage

// ==== src/ads_axis_flags.sv ====
// Ready and overwrite flags of one acceleration axis.
// Assumes sample and clear are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "ads_defines.svh"

module ads_axis_flags (
	input wire logic clk, // System clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic sample, // New axis sample completed
	input wire logic clear, // High byte of this axis read
	output logic ready, // New axis data ready
	output logic overwrite, // Unread axis data was overwritten
	output logic owEvent // Overwrite happening this cycle
);
	import ads_pkg::*;

	logic ready_q, ready_d;
	logic over_q, over_d;

	// Set wins over a clear in the same cycle
	assign owEvent = sample & ready_q;
	assign ready_d = sample | (ready_q & ~clear);
	assign over_d = owEvent | (over_q & ~clear);
	assign ready = ready_q;
	assign overwrite = over_q;

	// Flag storage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ready_q <= 1'b0;
			over_q <= 1'b0;
		end else begin
			ready_q <= ready_d;
			over_q <= over_d;
		end
	end

endmodule

// ==== src/ads_combined_flag.sv ====
// Combined flag set by any axis event and cleared once every axis high
// byte has been read since the last set.
// Assumes setEv and clrVec are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "ads_defines.svh"

module ads_combined_flag (
	input wire logic clk, // System clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic setEv, // Flag set event
	input wire ads_pkg::ads_axis_t clrVec, // Per-axis high-byte reads
	output logic flag // Combined flag
);
	import ads_pkg::*;

	logic flag_q, flag_d;
	ads_axis_t seen_q, seen_d;
	ads_axis_t seenNow;
	logic allRead;

	// Reads since the last set accumulate until all axes are covered
	assign seenNow = seen_q | clrVec;
	assign allRead = &seenNow;
	assign flag_d = setEv | (flag_q & ~allRead);
	assign seen_d = (setEv | allRead) ? `ADS_SEEN_RESET : seenNow;
	assign flag = flag_q;

	// Flag and read tracking storage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
			seen_q <= `ADS_SEEN_RESET;
		end else begin
			flag_q <= flag_d;
			seen_q <= seen_d;
		end
	end

endmodule

// ==== src/ads_sample_status.sv ====
// Sample status register: per-axis and combined ready and overwrite flags,
// read by the host through the device register port.
// Assumes all inputs come from logic on clk; sample pulses are one cycle.
`timescale 1ns/1ps
`include "ads_defines.svh"

// Behaviour
// - Address 0x00 shows this status view only while FIFO mode is 0b00.
// - Status updates on every acquired sample, tracking the axis outputs.
// - Bit 7 sets when a new sample overwrites unread axis data.
// - Bit 7 clears once X, Y and Z high bytes have been read.
// - Bit 6 sets on Z overwrite of unread data; clears on Z high read.
// - Bit 5 sets on Y overwrite of unread data; clears on Y high read.
// - Bit 4 sets on X overwrite of unread data; clears on X high read.
// - Bit 3 reads 1 when any enabled axis has a new acquisition.
// - Bit 3 clears after all three axis high bytes are read.
// - Bit 2 sets on new Z sample; clears on Z high-byte read.
// - Bit 1 sets on new Y sample; clears on Y high-byte read.
// - Bit 0 sets on new X sample; clears on X high-byte read.
module ads_sample_status (
	input wire logic clk, // System clock, 10 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire ads_pkg::ads_fmode_t fifoMode, // FIFO mode field
	input wire ads_pkg::ads_axis_t axisEnable, // Enabled axis channels
	input wire ads_pkg::ads_axis_t sampleDone, // Axis acquisition done
	input wire logic regRdStb, // Register read strobe
	input wire logic regWrStb, // Register write strobe
	input wire ads_pkg::ads_addr_t regAddr, // Register address
	output ads_pkg::ads_byte_t regRdData, // Read data, one cycle late
	output logic regRdValid, // Read data valid pulse
	output logic regWrIgnored, // Write to status address dropped
	output logic statusActive // Status view selected at 0x00
);
	import ads_pkg::*;

	ads_axis_t clrVec;
	ads_axis_t axisReady;
	ads_axis_t axisOver;
	ads_axis_t owEvent;
	ads_addr_t msbAddr [3];
	logic combReady;
	logic combOver;
	logic readySet;
	logic overSet;
	logic viewOn;
	logic statusHit;
	logic statusRead;
	ads_byte_t status;
	ads_byte_t rdMux;
	ads_byte_t rdData_q, rdData_d;
	logic rdValid_q;
	logic wrIgn_q, wrIgn_d;
	logic active_q;

	// High-byte output register addresses, one per axis
	assign msbAddr[0] = `ADS_OUT_X_MSB_ADDR;
	assign msbAddr[1] = `ADS_OUT_Y_MSB_ADDR;
	assign msbAddr[2] = `ADS_OUT_Z_MSB_ADDR;

	// Per-axis flag cells, cleared by reads of their high byte
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_axis
			assign clrVec[gi] = regRdStb && (regAddr == msbAddr[gi]);
			ads_axis_flags u_flags (
				.clk(clk),
				.rst_b(rst_b),
				.sample(sampleDone[gi]),
				.clear(clrVec[gi]),
				.ready(axisReady[gi]),
				.overwrite(axisOver[gi]),
				.owEvent(owEvent[gi])
			);
		end
	endgenerate

	// Combined event terms
	assign readySet = |(sampleDone & axisEnable);
	assign overSet = |owEvent;

	// Combined ready flag
	ads_combined_flag u_comb_ready (
		.clk(clk),
		.rst_b(rst_b),
		.setEv(readySet),
		.clrVec(clrVec),
		.flag(combReady)
	);

	// Combined overwrite flag
	ads_combined_flag u_comb_over (
		.clk(clk),
		.rst_b(rst_b),
		.setEv(overSet),
		.clrVec(clrVec),
		.flag(combOver)
	);

	// Status byte assembled from the flags
	assign status[`ADS_BIT_ZYXOW] = combOver;
	assign status[`ADS_BIT_ZOW] = axisOver[2];
	assign status[`ADS_BIT_YOW] = axisOver[1];
	assign status[`ADS_BIT_XOW] = axisOver[0];
	assign status[`ADS_BIT_ZYXDR] = combReady;
	assign status[`ADS_BIT_ZDR] = axisReady[2];
	assign status[`ADS_BIT_YDR] = axisReady[1];
	assign status[`ADS_BIT_XDR] = axisReady[0];

	// Address decode and view selection
	assign viewOn = (fifoMode == ADS_FM_DISABLED);
	assign statusHit = (regAddr == `ADS_STATUS_ADDR);
	assign statusRead = regRdStb && statusHit;
	assign rdMux = (statusRead && viewOn) ? status : `ADS_READ_IDLE;
	assign rdData_d = regRdStb ? rdMux : rdData_q;
	assign wrIgn_d = regWrStb && statusHit;

	// Read answer and status flags of the port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_q <= `ADS_READ_IDLE;
			rdValid_q <= 1'b0;
			wrIgn_q <= 1'b0;
			active_q <= 1'b0;
		end else begin
			rdData_q <= rdData_d;
			rdValid_q <= regRdStb;
			wrIgn_q <= wrIgn_d;
			active_q <= viewOn;
		end
	end

	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
	assign regWrIgnored = wrIgn_q;
	assign statusActive = active_q;

	// Checks of the flag behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	logic noSample;
	assign noSample = ~|sampleDone;

	// High bytes of X, Y and Z read in turn with no sample in between
	sequence s_read_all;
		(clrVec[0] && noSample) ##1 (clrVec[1] && noSample)
			##1 (clrVec[2] && noSample);
	endsequence

	// A sample lands on an axis whose data is still unread
	sequence s_overwrite(int ax);
		sampleDone[ax] && axisReady[ax];
	endsequence

	a_x_ready_set: assert property (
		sampleDone[0] |=> axisReady[0] && status[`ADS_BIT_XDR])
		else $error("X ready not set after sample");

	a_y_ready_clear: assert property (
		clrVec[1] && !sampleDone[1] |=> !status[`ADS_BIT_YDR])
		else $error("Y ready not cleared by high-byte read");

	a_z_ready_cycle: assert property (
		sampleDone[2] ##1 (clrVec[2] && !sampleDone[2])
			|-> status[`ADS_BIT_ZDR] ##1 !status[`ADS_BIT_ZDR])
		else $error("Z ready did not set then clear");

	a_z_over_set: assert property (
		s_overwrite(2) |=> status[`ADS_BIT_ZOW])
		else $error("Z overwrite not flagged");

	a_y_over_clear: assert property (
		status[`ADS_BIT_YOW] && clrVec[1] && !sampleDone[1]
			|=> !status[`ADS_BIT_YOW])
		else $error("Y overwrite not cleared by high-byte read");

	a_x_over_hold: assert property (
		!axisOver[0] && !(sampleDone[0] && axisReady[0])
			|=> !status[`ADS_BIT_XOW])
		else $error("X overwrite set without an overwrite");

	a_set_wins_clear: assert property (
		sampleDone[0] && clrVec[0] |=> axisReady[0])
		else $error("Clear beat a simultaneous sample");

	a_comb_ready_set: assert property (
		readySet |=> status[`ADS_BIT_ZYXDR])
		else $error("Combined ready not set by enabled sample");

	a_comb_ready_clr: assert property (
		s_read_all |=> !status[`ADS_BIT_ZYXDR])
		else $error("Combined ready survived reads of all axes");

	a_comb_over_set: assert property (
		s_overwrite(1) |=> status[`ADS_BIT_ZYXOW])
		else $error("Combined overwrite not set on overwrite");

	a_comb_over_clr: assert property (
		s_read_all |=> !status[`ADS_BIT_ZYXOW])
		else $error("Combined overwrite survived reads of all axes");

	a_status_view: assert property (
		statusRead && viewOn |=> regRdValid
			&& regRdData == $past(status))
		else $error("Status view not returned at address 0x00");

	a_fifo_hides: assert property (
		statusRead && !viewOn |=> regRdValid
			&& regRdData == `ADS_READ_IDLE)
		else $error("Status view shown while FIFO mode active");

	a_update_cause: assert property (
		!$stable(status) |-> $past(!noSample || (|clrVec)))
		else $error("Status changed without sample or read");

	a_write_ignored: assert property (
		regWrStb && noSample && !regRdStb |=> $stable(status))
		else $error("Write altered the read-only status");

	a_write_flagged: assert property (
		regWrStb && statusHit |=> regWrIgnored)
		else $error("Dropped write not reported");

endmodule

// ==== bench/ads_host_model.sv ====
// Host side of the register port: issues reads and writes.
// Assumes the status block answers one cycle after the strobe.
`timescale 1ns/1ps
module ads_host_model (
	input wire logic clk, // System clock
	output ads_pkg::ads_addr_t regAddr, // Register address
	output logic regRdStb, // Read strobe
	output logic regWrStb, // Write strobe
	input wire ads_pkg::ads_byte_t regRdData // Read data
);
	import ads_pkg::*;
	// Idle strobes low; address toggles between accesses
	initial begin
		regRdStb = 1'h0;
		regWrStb = 1'h0;
		regAddr = 8'hff;
	end
	// One read: strobe for one cycle, take data in the answer cycle
	task automatic rd(input ads_addr_t a, output ads_byte_t d);
		@(posedge clk);
		regRdStb <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRdStb <= 1'h0;
		regAddr <= ~a;
		@(negedge clk);
		d = regRdData;
	endtask
	// One write, which the block must drop
	task automatic wr(input ads_addr_t a);
		@(posedge clk);
		regWrStb <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regWrStb <= 1'h0;
		regAddr <= ~a;
	endtask
endmodule

// ==== bench/accel_data_ready_status_tb.sv ====
// Testbench of the sample status block with host model and flag model.
// Assumes design sources and the host model are compiled first.
`timescale 1ns/1ps
`include "ads_defines.svh"
module accel_data_ready_status_tb;
	import ads_pkg::*;
	logic clk, rst_b, regRdStb, regWrStb, regRdValid, regWrIgnored;
	logic statusActive, cDr, cOw, expV, expW, expA;
	ads_fmode_t fifoMode;
	ads_axis_t axisEnable, sampleDone, dr, ow, sDr, sOw, clr;
	ads_addr_t regAddr;
	ads_byte_t regRdData, expD, d;
	int errors, total_checks, cyc;
	ads_sample_status i_dut (.clk(clk), .rst_b(rst_b), .fifoMode(fifoMode),
		.axisEnable(axisEnable), .sampleDone(sampleDone),
		.regRdStb(regRdStb), .regWrStb(regWrStb), .regAddr(regAddr),
		.regRdData(regRdData), .regRdValid(regRdValid),
		.regWrIgnored(regWrIgnored), .statusActive(statusActive));
	ads_host_model h (.clk(clk), .regAddr(regAddr), .regRdStb(regRdStb),
		.regWrStb(regWrStb), .regRdData(regRdData));
	// Expected flag and output helpers
	function automatic ads_addr_t hi(input int i);
		return i == 0 ? `ADS_OUT_X_MSB_ADDR : i == 1 ? `ADS_OUT_Y_MSB_ADDR :
			`ADS_OUT_Z_MSB_ADDR;
	endfunction
	function automatic ads_axis_t clrOf(input logic s, input ads_addr_t a);
		return {s && a == hi(2), s && a == hi(1), s && a == hi(0)};
	endfunction
	function automatic logic comb(input logic f, s, input ads_axis_t seen);
		return s | (f & ~&seen);
	endfunction
	task automatic chk(input string n, input ads_byte_t e, input ads_byte_t g);
		total_checks++;
		if (e !== g) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rdSt(input ads_byte_t e);
		h.rd(`ADS_STATUS_ADDR, d);
		chk("status", e, d);
	endtask
	task automatic pulse(input ads_axis_t s);
		@(posedge clk);
		sampleDone <= s;
		@(posedge clk);
		sampleDone <= 3'h0;
	endtask
	task automatic clrAll();
		for (int i = 0; i < 3; i++) h.rd(hi(i), d);
	endtask
	// Flag model, updated on the same edges as the design
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{dr, ow, sDr, sOw, cDr, cOw, expV, expW, expA} <= '0;
		end else begin
			clr = clrOf(regRdStb, regAddr);
			dr <= sampleDone | (dr & ~clr);
			ow <= (sampleDone & dr) | (ow & ~clr);
			cDr <= comb(cDr, |(sampleDone & axisEnable), sDr | clr);
			cOw <= comb(cOw, |(sampleDone & dr), sOw | clr);
			sDr <= |(sampleDone & axisEnable) ? 3'h0 : sDr | clr;
			sOw <= |(sampleDone & dr) ? 3'h0 : sOw | clr;
			expV <= regRdStb;
			if (regRdStb) expD <= (regAddr == `ADS_STATUS_ADDR &&
				fifoMode == ADS_FM_DISABLED) ? {cOw, ow, cDr, dr} : 8'h00;
			expW <= regWrStb && regAddr == `ADS_STATUS_ADDR;
			expA <= fifoMode == ADS_FM_DISABLED;
		end
	end
	// Output checks in mid cycle, and the hang limit
	always @(negedge clk) begin
		cyc++;
		if (rst_b) begin
			chk("valid", expV, regRdValid);
			if (expV) chk("data", expD, regRdData);
			chk("wrIgnored", expW, regWrIgnored);
			chk("active", expA, statusActive);
		end
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// Main sequence
	initial begin
		rst_b = 1'h0;
		fifoMode = ADS_FM_DISABLED;
		axisEnable = 3'h7;
		sampleDone = 3'h0;
		errors = 0;
		total_checks = 0;
		cyc = 0;
		void'($urandom(32'h5e33_372e));
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		rdSt(8'h00);
		pulse(3'h1);
		rdSt(8'h09);
		pulse(3'h1);
		rdSt(8'h99);
		h.wr(`ADS_STATUS_ADDR);
		rdSt(8'h99);
		h.rd(hi(0), d);
		rdSt(8'h88);
		clrAll();
		rdSt(8'h00);
		$display("Test walk done");
		for (int i = 0; i < 3; i++) begin
			pulse(3'h1 << i);
			pulse(3'h1 << i);
			rdSt(8'h88 | (8'h11 << i));
			h.rd(hi(i), d);
			rdSt(8'h88);
		end
		clrAll();
		axisEnable <= 3'h0;
		pulse(3'h7);
		rdSt(8'h07);
		clrAll();
		axisEnable <= 3'h7;
		$display("Test axes done");
		pulse(3'h1);
		fork
			pulse(3'h1);
			h.rd(hi(0), d);
		join
		rdSt(8'h99);
		clrAll();
		for (int m = 1; m < 4; m++) begin
			fifoMode <= ads_fmode_t'(m);
			pulse(3'h7);
			rdSt(8'h00);
		end
		fifoMode <= ADS_FM_DISABLED;
		rdSt(8'hff);
		clrAll();
		$display("Test modes done");
		fork
		begin
			repeat (300) begin
				@(posedge clk);
				sampleDone <= ($urandom % 4 == 0) ? 3'($urandom) : 3'h0;
			end
			@(posedge clk);
			sampleDone <= 3'h0;
		end
		begin
			repeat (90) h.rd(($urandom % 2) ? hi($urandom % 3) : 8'h00, d);
		end
		join
		@(negedge clk);
		rdSt({cOw, ow, cDr, dr});
		$display("Test random done");
		test_done();
	end
endmodule
